// ---- shared/spfirc_defines.svh ----
`ifndef SPFIRC_DEFINES_SVH
`define SPFIRC_DEFINES_SVH
// Byte and bit counts
`define SPFIRC_BYTE_W 8
`define SPFIRC_MSB 7
`define SPFIRC_LAST_BIT 3'h7
`define SPFIRC_BIT1 3'h1
// Master half-bit counts
`define SPFIRC_HALF_LAST 4'hF
`define SPFIRC_HALF_BIT1 4'h3
// Half-bit length in mclk cycles per rate select
`define SPFIRC_HDIV2 7'h01
`define SPFIRC_HDIV8 7'h04
`define SPFIRC_HDIV32 7'h10
`define SPFIRC_HDIV128 7'h40
// Reset values
`define SPFIRC_BYTE_RST 8'h00
`define SPFIRC_MASTER_RST 1'h1
`endif

// ---- shared/spfirc_pkg.sv ----
package spfirc_pkg;
  // Control bits written by software
  typedef struct packed {
    logic rx_irq_enable;
    logic master_select;
    logic cpol;
    logic clock_phase;
    logic tx_irq_enable;
    logic port_enable;
    logic mode_fault_enable;
    logic error_irq_enable;
    logic rate_select_hi;
    logic rate_select_lo;
  } spfirc_ctrl_t;
  // Status flags
  typedef struct packed {
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
  } spfirc_stat_t;
  // Master shifter states
  typedef enum logic [0:0] {M_IDLE, M_SHIFT} spfirc_mst_t;
endpackage

// ---- logic/spfirc_top.sv ----
// Operation
// - Mode fault flag sets only while mode fault enable is one.
// - Rx full, overrun, mode fault share one request; error enable gates both.
// - Master with fault enable: slave select low sets mode fault.
// - Master fault clears enable, sets tx empty, clears counter, frees pins.
// - Mode fault never alters master select.
// - Slave: select rising during a transfer sets mode fault.
// - Phase 0 slave transfer: select fall to clock idle after bit eight.
// - Phase 1 slave transfer: first clock edge to idle after last bit.
// - Phase 0 select then deselect faults; phase 1 does not.
// - Slave fault requests interrupt but leaves port enabled.
// - Deselected slave floats data out and ignores clock edges.
// - Fault clears by status read then control write, no fault meanwhile.
// - Tx empty sets on buffer to shifter move; tx request when enabled.
// - Rx full sets on byte received; rx request needs enable and port.
// - Master starts queued byte right after previous transfer.
// - Slave without new byte resends last shifter value.
// - Port disabled: tx empty set, abort, clear shifter, counter, pins.
// - Port disable leaves control bits and rx, overrun, fault flags unchanged.
// - Wait mode keeps running; enabled request raises wake.
// - Stop freezes system-domain registers, not the link shifter or synchronisers; reset on stop exit aborts.
// - Overrun when rx full at bit one capture; new byte dropped.
`timescale 1ns/100ps
module spfirc_top (
  // System clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Link clock from the far master
  input wire logic link_sck,
  // Software access strobes
  input wire logic ctrl_wr,
  input wire spfirc_pkg::spfirc_ctrl_t ctrl_in,
  input wire logic stat_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_in,
  input wire logic data_rd,
  input wire logic stop_mode,
  // Register views
  output spfirc_pkg::spfirc_ctrl_t ctrl,
  output spfirc_pkg::spfirc_stat_t stat,
  output logic [7:0] rx_data,
  // Requests
  output logic tx_irq,
  output logic rx_err_irq,
  output logic wake_req,
  // Pins
  input wire logic ss_n_pin,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic sck_oe,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  output logic port_owns_pins
);
`include "spfirc_defines.svh"

  ////////////////////////////////////////////////////////////////////////
  // Link domain: slave shifter on the far master's clock
  logic [2:0] lbit;
  logic [7:0] lsh;
  logic [7:0] lrx;
  logic ldone_t;
  logic lbit1_t;
  logic lact;
  logic [2:0] next_lbit;
  logic [7:0] next_lsh;
  logic [7:0] next_lrx;
  logic next_ldone_t;
  logic next_lbit1_t;
  logic next_lact;
  logic [7:0] shreg;

  // Next values for the sample edge
  always_comb begin
    next_lsh = {lsh[6:0], mosi_in};
    next_lbit = lbit + 3'h1;
    next_lrx = lrx;
    next_ldone_t = ldone_t;
    next_lbit1_t = lbit1_t;
    next_lact = 1'b1;
    if (lbit == `SPFIRC_BIT1) begin
      next_lbit1_t = ~lbit1_t;
    end
    if (lbit == `SPFIRC_LAST_BIT) begin
      next_lrx = next_lsh;
      next_ldone_t = ~ldone_t;
      next_lact = 1'b0;
    end
  end

  // A high select holds the shifter cleared, so stray edges do nothing
  // ignore edges deselected
  always_ff @(posedge link_sck or posedge ss_n_pin) begin
    if (ss_n_pin) begin
      lbit <= 3'h0;
      lsh <= `SPFIRC_BYTE_RST;
      lact <= 1'b0;
    end else begin
      lbit <= next_lbit;
      lsh <= next_lsh;
      lact <= next_lact;
    end
  end

  // Result and event toggles survive deselect; system reset clears them
  // so the edge detectors across the crossing start from a known level
  always_ff @(posedge link_sck or negedge rstn) begin
    if (!rstn) begin
      lrx <= `SPFIRC_BYTE_RST;
      ldone_t <= 1'b0;
      lbit1_t <= 1'b0;
    end else if (!ss_n_pin) begin
      lrx <= next_lrx;
      ldone_t <= next_ldone_t;
      lbit1_t <= next_lbit1_t;
    end
  end

  // Slave data out on the drive edge; shreg is static during a byte
  // resend shifter value
  always_ff @(negedge link_sck or posedge ss_n_pin) begin
    if (ss_n_pin) begin
      miso_out <= 1'b0;
    end else begin
      miso_out <= shreg[`SPFIRC_LAST_BIT - lbit];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain
  logic [1:0] ss_q;
  logic [1:0] miso_q;
  logic [2:0] done_q;
  logic [2:0] b1_q;
  logic [2:0] act_q;
  logic ss_prev;

  // Two stages for select and miso, three for the toggles; only the second and later stages are read
  always_ff @(posedge mclk) begin
    ss_q <= {ss_q[0], ss_n_pin};
    miso_q <= {miso_q[0], miso_in};
    done_q <= {done_q[1:0], ldone_t};
    b1_q <= {b1_q[1:0], lbit1_t};
    act_q <= {act_q[1:0], lact};
    ss_prev <= ss_q[1];
  end

  logic ss_s;
  logic s_done;
  logic s_bit1;
  logic s_start1;
  logic ss_rise;
  logic ss_fall;
  assign ss_s = ss_q[1];
  assign s_done = done_q[2] ^ done_q[1];
  assign s_bit1 = b1_q[2] ^ b1_q[1];
  assign s_start1 = act_q[1] & ~act_q[2];
  assign ss_rise = ss_s & ~ss_prev;
  assign ss_fall = ~ss_s & ss_prev;

  ////////////////////////////////////////////////////////////////////////
  // System domain state
  spfirc_pkg::spfirc_mst_t mst;
  spfirc_pkg::spfirc_mst_t next_mst;
  spfirc_pkg::spfirc_ctrl_t next_ctrl;
  spfirc_pkg::spfirc_stat_t next_stat;
  logic [7:0] txbuf;
  logic [7:0] next_txbuf;
  logic [7:0] next_shreg;
  logic [7:0] mrx;
  logic [7:0] next_mrx;
  logic [7:0] next_rx_data;
  logic [3:0] half;
  logic [3:0] next_half;
  logic [6:0] hcnt;
  logic [6:0] next_hcnt;
  logic s_xfer;
  logic next_s_xfer;
  logic drop;
  logic next_drop;
  logic arm_fault;
  logic next_arm_fault;
  logic arm_rx;
  logic next_arm_rx;
  logic next_sck;
  logic next_mosi;
  logic [6:0] hlen;
  logic fault_cond;
  logic master_on;
  logic slave_on;
  logic tick;
  logic byte_done;
  logic bit1_cap;
  logic [7:0] got;

  // Half-bit length from the rate select pair
  always_comb begin
    case ({ctrl.rate_select_hi, ctrl.rate_select_lo})
      2'h0: hlen = `SPFIRC_HDIV2;
      2'h1: hlen = `SPFIRC_HDIV8;
      2'h2: hlen = `SPFIRC_HDIV32;
      default: hlen = `SPFIRC_HDIV128;
    endcase
  end

  // Roles and fault conditions
  always_comb begin
    master_on = ctrl.port_enable & ctrl.master_select;
    slave_on = ctrl.port_enable & ~ctrl.master_select;
    tick = (mst == spfirc_pkg::M_SHIFT) && (hcnt == hlen - 7'h1);
    fault_cond = 1'b0;
    if (master_on && !ss_s) begin
      fault_cond = 1'b1;
    end
    if (slave_on && ss_rise && s_xfer) begin
      fault_cond = 1'b1;
    end
  end

  // Next values of the control, flags, buffers and master shifter
  always_comb begin
    next_ctrl = ctrl;
    next_stat = stat;
    next_txbuf = txbuf;
    next_shreg = shreg;
    next_mrx = mrx;
    next_rx_data = rx_data;
    next_half = half;
    next_hcnt = hcnt;
    next_mst = mst;
    next_s_xfer = s_xfer;
    next_drop = drop;
    next_arm_fault = arm_fault;
    next_arm_rx = arm_rx;
    next_sck = sck_out;
    next_mosi = mosi_out;
    byte_done = 1'b0;
    bit1_cap = 1'b0;
    got = lrx;
    // Software control write
    if (ctrl_wr) begin
      next_ctrl = ctrl_in;
    end
    if (data_wr && stat.tx_empty_flag) begin
      next_txbuf = data_in;
      next_stat.tx_empty_flag = 1'b0;
    end
    // Master shifter
    case (mst)
      spfirc_pkg::M_IDLE: begin
        next_sck = ctrl.cpol;
        if (master_on && !stat.tx_empty_flag) begin
          next_shreg = txbuf;
          next_mosi = txbuf[`SPFIRC_MSB];
          next_stat.tx_empty_flag = 1'b1;
          next_half = 4'h0;
          next_hcnt = 7'h0;
          next_sck = ctrl.cpol ^ ctrl.clock_phase;
          next_mst = spfirc_pkg::M_SHIFT;
        end
      end
      spfirc_pkg::M_SHIFT: begin
        next_hcnt = hcnt + 7'h1;
        if (tick) begin
          next_hcnt = 7'h0;
          next_half = half + 4'h1;
          next_sck = ctrl.cpol ^ (~half[0] ^ ctrl.clock_phase);
          if (!half[0]) begin
            next_mrx = {mrx[6:0], miso_q[1]};
            bit1_cap = (half == `SPFIRC_HALF_BIT1 - 4'h1);
          end else begin
            next_shreg = {shreg[6:0], 1'b0};
            next_mosi = shreg[6];
          end
          if (half == `SPFIRC_HALF_LAST) begin
            byte_done = 1'b1;
            got = mrx;
            next_sck = ctrl.cpol;
            next_mst = spfirc_pkg::M_IDLE;
          end
        end
      end
      default: next_mst = spfirc_pkg::M_IDLE;
    endcase
    // Slave loads a new byte between transfers, else keeps the old one
    if (slave_on && !s_xfer && ss_s && !stat.tx_empty_flag) begin
      next_shreg = txbuf;
      next_stat.tx_empty_flag = 1'b1;
    end
    if (slave_on) begin
      if ((ss_fall && !ctrl.clock_phase) || s_start1) begin
        next_s_xfer = 1'b1;
      end
      if (s_done || ss_rise) begin
        next_s_xfer = 1'b0;
      end
      if (s_done) begin
        byte_done = 1'b1;
      end
      bit1_cap = s_bit1;
    end
    if (bit1_cap && stat.rx_full_flag) begin
      next_drop = 1'b1;
    end
    // Receive side clears before the byte lands, so the set wins
    if (stat_rd) begin
      next_arm_rx = stat.rx_full_flag | stat.overrun_flag;
    end
    if (data_rd && arm_rx) begin
      next_stat.rx_full_flag = 1'b0;
      next_stat.overrun_flag = 1'b0;
      next_arm_rx = 1'b0;
    end
    if (bit1_cap && stat.rx_full_flag) begin
      next_stat.overrun_flag = 1'b1;
    end
    if (byte_done) begin
      next_drop = 1'b0;
      if (!drop && !(bit1_cap && stat.rx_full_flag)) begin
        next_rx_data = got;
        next_stat.rx_full_flag = 1'b1;
      end
    end
    if (stat_rd) begin
      next_arm_fault = stat.mode_fault_flag;
    end
    if (ctrl_wr && arm_fault && !fault_cond) begin
      next_stat.mode_fault_flag = 1'b0;
      next_arm_fault = 1'b0;
    end
    if (fault_cond) begin
      next_arm_fault = 1'b0;
    end
    if (fault_cond && ctrl.mode_fault_enable) begin
      next_stat.mode_fault_flag = 1'b1;
      if (ctrl.master_select) begin
        next_ctrl.port_enable = 1'b0;
      end
    end
    if (!next_ctrl.port_enable) begin
      next_stat.tx_empty_flag = 1'b1;
      next_shreg = `SPFIRC_BYTE_RST;
      next_mrx = `SPFIRC_BYTE_RST;
      next_half = 4'h0;
      next_hcnt = 7'h0;
      next_mst = spfirc_pkg::M_IDLE;
      next_s_xfer = 1'b0;
      next_drop = 1'b0;
      next_sck = ctrl.cpol;
      next_mosi = 1'b0;
    end
  end

  // Registers; stop freezes everything, reset restores everything
  // flags reset only here
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl <= '0;
      ctrl.master_select <= `SPFIRC_MASTER_RST;
      stat <= '0;
      stat.tx_empty_flag <= 1'b1;
      txbuf <= `SPFIRC_BYTE_RST;
      shreg <= `SPFIRC_BYTE_RST;
      mrx <= `SPFIRC_BYTE_RST;
      rx_data <= `SPFIRC_BYTE_RST;
      half <= 4'h0;
      hcnt <= 7'h0;
      mst <= spfirc_pkg::M_IDLE;
      s_xfer <= 1'b0;
      drop <= 1'b0;
      arm_fault <= 1'b0;
      arm_rx <= 1'b0;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
    end else if (!stop_mode) begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      txbuf <= next_txbuf;
      shreg <= next_shreg;
      mrx <= next_mrx;
      rx_data <= next_rx_data;
      half <= next_half;
      hcnt <= next_hcnt;
      mst <= next_mst;
      s_xfer <= next_s_xfer;
      drop <= next_drop;
      arm_fault <= next_arm_fault;
      arm_rx <= next_arm_rx;
      sck_out <= next_sck;
      mosi_out <= next_mosi;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Requests and pin ownership, registered for clean outputs
  logic next_tx_irq;
  logic next_rx_err_irq;
  logic next_owns;
  logic next_miso_oe;

  always_comb begin
    next_tx_irq = next_stat.tx_empty_flag & next_ctrl.tx_irq_enable;
    next_rx_err_irq = (next_stat.rx_full_flag & next_ctrl.rx_irq_enable &
                       next_ctrl.port_enable) |
                      ((next_stat.overrun_flag | next_stat.mode_fault_flag) &
                       next_ctrl.error_irq_enable);
    next_owns = next_ctrl.port_enable;
    next_miso_oe = next_ctrl.port_enable & ~next_ctrl.master_select & ~ss_s;
  end

  // Requests freeze in stop with the flags, or they would show moves
  // that the held registers never make
  // wake from wait
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_irq <= 1'b0;
      rx_err_irq <= 1'b0;
      wake_req <= 1'b0;
      port_owns_pins <= 1'b0;
      miso_oe <= 1'b0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
    end else if (!stop_mode) begin
      tx_irq <= next_tx_irq;
      rx_err_irq <= next_rx_err_irq;
      wake_req <= next_tx_irq | next_rx_err_irq;
      port_owns_pins <= next_owns;
      miso_oe <= next_miso_oe;
      sck_oe <= next_owns & next_ctrl.master_select;
      mosi_oe <= next_owns & next_ctrl.master_select;
    end
  end

endmodule

// ---- verification/spfirc_checker.sv ----
`timescale 1ns/100ps
module spfirc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register views and strobes
  input wire spfirc_pkg::spfirc_ctrl_t ctrl,
  input wire spfirc_pkg::spfirc_stat_t stat,
  input wire logic ctrl_wr,
  input wire logic ss_n_pin,
  // Requests and pin control
  input wire logic tx_irq,
  input wire logic rx_err_irq,
  input wire logic wake_req,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic port_owns_pins
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////
  // Request sources; levels are checked over two cycles to absorb the flop
  logic err_src;
  logic rx_src;
  logic tx_src;
  assign err_src = (stat.overrun_flag | stat.mode_fault_flag)
    & ctrl.error_irq_enable;
  assign rx_src = stat.rx_full_flag & ctrl.rx_irq_enable & ctrl.port_enable;
  assign tx_src = stat.tx_empty_flag & ctrl.tx_irq_enable;
  // Fault rise not caused by a software control write
  sequence s_fault;
    $rose(stat.mode_fault_flag) && !$past(ctrl_wr);
  endsequence
  sequence s_mst_fault;
    s_fault ##0 ctrl.master_select;
  endsequence
  a_fault_needs_en: assert property (
    s_fault |-> $past(ctrl.mode_fault_enable)) else $error("fault unarmed");
  a_fault_keeps_mst: assert property (
    s_fault |-> $stable(ctrl.master_select)) else $error("role changed");
  a_master_fault: assert property (
    s_mst_fault |-> ##[0:1] (!ctrl.port_enable && stat.tx_empty_flag))
    else $error("master fault left port on");
  a_slave_fault: assert property (
    s_fault ##0 (!ctrl.master_select && $past(ctrl.port_enable))
    |-> ctrl.port_enable) else $error("slave fault cut port");
  a_err_irq_on: assert property (
    err_src [*2] |-> rx_err_irq) else $error("error request missing");
  a_rx_irq_off: assert property (
    (!err_src && !rx_src) [*2] |-> !rx_err_irq) else $error("stray request");
  a_tx_irq_on: assert property (
    tx_src [*2] |-> tx_irq) else $error("tx request missing");
  a_tx_irq_drop: assert property (
    !tx_src [*2] |-> !tx_irq) else $error("tx request held");
  a_wake_req: assert property (
    (tx_irq || rx_err_irq) [*2] |-> wake_req) else $error("no wake");
  a_miso_float: assert property (
    ss_n_pin [*6] |-> !miso_oe) else $error("miso driven unselected");
  a_port_off: assert property (
    !ctrl.port_enable [*2] |-> !port_owns_pins && !sck_oe && !mosi_oe
    && !miso_oe && stat.tx_empty_flag) else $error("disabled port active");
endmodule

// ---- verification/spfirc_far_model.sv ----
`timescale 1ns/100ps
module spfirc_far_model (
  // Clock from the block as master
  input wire logic sck_out,
  input wire logic mosi_out,
  // Lines toward the block
  output logic link_sck,
  output logic ss_n,
  output logic mosi,
  output logic miso_in
);
  logic [7:0] sh;
  logic [7:0] seen;
  logic [7:0] replies[$];
  int nb;
  // Idle lines: clock still, slave deselected
  initial begin
    link_sck = 1'h0;
    ss_n = 1'h1;
    mosi = 1'h0;
    miso_in = 1'h0;
    sh = 8'h00;
    seen = 8'h00;
    nb = 0;
  end
  // Master data captured on the rising clock, MSB first
  always @(posedge sck_out) seen = {seen[6:0], mosi_out};
  //////////////////////////////
  // Reply shifter moves on the falling edge so data is settled at the rise
  always @(negedge sck_out) begin
    nb = nb + 1;
    sh = {sh[6:0], sh[7]};
    if (nb == 8) begin
      nb = 0;
      if (replies.size() > 0) sh = replies.pop_front();
    end
    miso_in = sh[7];
  end
  // Load the first reply while idle; spurious edges at start are forgotten
  task prime(input logic [7:0] b);
    sh = b;
    miso_in = b[7];
    nb = 0;
  endtask
  // Frame of n bits, MSB first; the clock runs only inside the frame
  task frame(input logic [7:0] b, input int n, input int hold);
    ss_n = 1'h0;
    #80;
    for (int i = 0; i < n; i++) begin
      mosi = b[7 - i];
      #80 link_sck = 1'h1;
      #80 link_sck = 1'h0;
    end
    #(hold) ss_n = 1'h1;
    mosi = ~mosi;
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'h0;
  logic rstn, ctrl_wr, stat_rd, data_wr, data_rd, stop_mode;
  spfirc_pkg::spfirc_ctrl_t ctrl_in, ctrl;
  spfirc_pkg::spfirc_stat_t stat;
  logic [7:0] data_in, rx_data, b0, b1;
  logic tx_irq, rx_err_irq, wake_req, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, port_owns_pins, link_sck, ss_n_pin, mosi_in;
  logic miso_in;
  logic auto_rd = 1'h1;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 10;
  int cyc = 0;
  logic [7:0] exp_q[$];
  int t_q[$];
  spfirc_top dut (.mclk(mclk), .rstn(rstn), .link_sck(link_sck),
    .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .stat_rd(stat_rd),
    .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd),
    .stop_mode(stop_mode), .ctrl(ctrl), .stat(stat), .rx_data(rx_data),
    .tx_irq(tx_irq), .rx_err_irq(rx_err_irq), .wake_req(wake_req),
    .ss_n_pin(ss_n_pin), .mosi_in(mosi_in), .miso_in(miso_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .port_owns_pins(port_owns_pins));
  spfirc_far_model far (.sck_out(sck_out), .mosi_out(mosi_out),
    .link_sck(link_sck), .ss_n(ss_n_pin), .mosi(mosi_in),
    .miso_in(miso_in));
  //////////////////////////////
  // Clock and cycle count
  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task check(input string what, input logic [9:0] seen, input logic [9:0] e);
    checks_done++;
    if (seen !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, seen);
    end
  endtask
  // Strobes are one cycle wide; automatic so two processes can share them
  task automatic pulse(input int k);
    @(posedge mclk);
    #1 case (k)
      0: ctrl_wr = 1'h1;
      1: stat_rd = 1'h1;
      2: data_rd = 1'h1;
      default: data_wr = 1'h1;
    endcase
    @(posedge mclk);
    #1 case (k)
      0: ctrl_wr = 1'h0;
      1: stat_rd = 1'h0;
      2: data_rd = 1'h0;
      default: data_wr = 1'h0;
    endcase
  endtask
  task cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr_ctrl(input logic [9:0] v);
    ctrl_in = v;
    pulse(0);
  endtask
  task wr_data(input logic [7:0] b);
    int i;
    i = 0;
    while (stat.tx_empty_flag !== 1'h1 && i < 200) begin
      cycles(1);
      i++;
    end
    if (i == 200) miscompares++;
    data_in = b;
    pulse(3);
  endtask
  // Received bytes are matched against the oldest note, then read out
  always @(posedge stat.rx_full_flag) begin
    #1 t_q.push_back(cyc);
    if (exp_q.size() > 0) check("rx_data", rx_data, exp_q.pop_front());
    if (auto_rd) begin
      pulse(1);
      pulse(2);
    end
  end
  task wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog, well past the expected run of about five hundred cycles
  initial begin
    #800000;
    miscompares++;
    wrap_up;
  end
  //////////////////////////////
  initial begin
    rstn = 1'h0;
    {ctrl_wr, stat_rd, data_wr, data_rd, stop_mode} = 5'h00;
    ctrl_in = 10'h000;
    data_in = 8'h00;
    repeat (16) @(posedge mclk);
    #1 rstn = 1'h1;
    check("ctrl", ctrl, 10'h100);
    check("stat", stat, 10'h001);
    wr_ctrl(10'h334);
    far.frame(8'h00, 0, 400);
    cycles(6);
    check("unarmed", stat.mode_fault_flag, 10'h000);
    // First byte left unread so the second one overruns
    auto_rd = 1'h0;
    // Rate 1: the two-flop miso path needs half bits of three cycles or more
    wr_ctrl(10'h33D);
    b0 = 8'($random(seed));
    far.prime(b0);
    far.replies.push_back(8'($random(seed)));
    exp_q.push_back(b0);
    wr_data(8'($random(seed)));
    b1 = 8'($random(seed));
    wr_data(b1);
    cycles(140);
    check("mosi", far.seen, b1);
    check("ovr", stat.overrun_flag, 10'h001);
    check("kept", rx_data, b0);
    check("err irq", rx_err_irq, 10'h001);
    pulse(1);
    pulse(2);
    cycles(2);
    check("clr", stat, 10'h001);
    // Queued pair with a stop inside the first byte
    auto_rd = 1'h1;
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    far.prime(b0);
    far.replies.push_back(b1);
    exp_q.push_back(b0);
    exp_q.push_back(b1);
    wr_data(8'($random(seed)));
    wr_data(8'($random(seed)));
    cycles(4);
    stop_mode = 1'h1;
    cycles(80);
    check("frozen", stat.rx_full_flag, 10'h000);
    stop_mode = 1'h0;
    cycles(150);
    check("gap", (t_q[2] - t_q[1]) inside {[64:66]}, 10'h001);
    // Master sees select low
    far.frame(8'h00, 0, 400);
    cycles(6);
    check("mfault", stat, 10'h003);
    check("mctrl", ctrl, 10'h32D);
    check("owns", port_owns_pins, 10'h000);
    pulse(1);
    wr_ctrl(10'h32C);
    cycles(2);
    check("mclr", stat.mode_fault_flag, 10'h000);
    // Slave byte, then select and deselect with no clocks
    wr_ctrl(10'h21F);
    b0 = 8'($random(seed));
    exp_q.push_back(b0);
    far.frame(b0, 8, 80);
    cycles(10);
    check("rx count", t_q.size(), 10'h004);
    far.frame(8'h00, 0, 400);
    cycles(8);
    check("sfault", stat.mode_fault_flag, 10'h001);
    check("pe kept", ctrl.port_enable, 10'h001);
    wr_ctrl(10'h20F);
    cycles(2);
    check("keep", stat, 10'h003);
    check("ctrl off", ctrl, 10'h20F);
    pulse(1);
    wr_ctrl(10'h25C);
    cycles(2);
    check("sclr", stat.mode_fault_flag, 10'h000);
    far.frame(8'h00, 0, 400);
    cycles(8);
    check("cpha1", stat.mode_fault_flag, 10'h000);
    wr_ctrl(10'h21C);
    far.frame(8'($random(seed)), 4, 80);
    cycles(8);
    check("mid", stat.mode_fault_flag, 10'h001);
    wrap_up;
  end
endmodule
bind spfirc_top spfirc_checker u_chk (.mclk(mclk), .rstn(rstn),
  .ctrl(ctrl), .stat(stat), .ctrl_wr(ctrl_wr), .ss_n_pin(ss_n_pin),
  .tx_irq(tx_irq), .rx_err_irq(rx_err_irq), .wake_req(wake_req),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .port_owns_pins(port_owns_pins));
